// [bench/free_timer_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module free_timer_tb;
   logic                ref_clk_i    = 1'b0;
   logic                rstn_i       = 1'b0;
   timer_pkg::axi_req_t req          = '0;
   timer_pkg::axi_rsp_t rsp;
   logic                mask         = 1'b1;
   logic                halt         = 1'b1;
   logic                ext_pin;
   logic [1:0]          cap_pin;
   logic [1:0]          cmp_pin;
   logic [1:0]          cmp_en;
   logic                irq;
   logic [7:0]          v;
   logic [1:0]          r;
   int                  n_errors     = 0;
   int                  total_checks = 0;
   localparam logic [7:0] RST [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
      8'hFF, 8'hFC, 8'hFF, 8'hFC, 8'h00, 8'h00, 8'h80, 8'h00};
   always #4 ref_clk_i = ~ref_clk_i;
   free_timer free_timer_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_req_i(req),
      .bus_rsp_o(rsp), .irq_mask_i(mask), .halt_i(halt), .external_clock_pin_i(ext_pin),
      .capture_input_pin_i(cap_pin), .compare_output_pin_o(cmp_pin),
      .compare_output_enable_o(cmp_en), .timer_irq_o(irq));
   pin_source pin_source_inst (.ref_clk_i(ref_clk_i), .ext_clk_o(ext_pin), .cap_o(cap_pin));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      @(posedge ref_clk_i);
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      req.awaddr  <= {i, 2'b00};
      req.wdata   <= {24'h000000, d};
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (rsp.awready === 1'b1) begin
            req.awvalid <= 1'b0;
            req.wvalid  <= 1'b0;
         end
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] i, output logic [7:0] d);
      @(posedge ref_clk_i);
      req.arvalid <= 1'b1;
      req.araddr  <= {i, 2'b00};
      req.rready  <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      d = rsp.rdata[7:0];
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] i, input logic [7:0] e);
      rd(i, v);
      chk(v, e);
   endtask
   task automatic run(input int n);
      @(posedge ref_clk_i);
      halt <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
      halt <= 1'b1;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 15; i++) rc(4'(i), RST[i]);
      wr(timer_pkg::IDX_STATUS, 8'hFF);
      rc(timer_pkg::IDX_STATUS, 8'h00);
      rd(4'hF, v);
      chk(8'(r), 8'(timer_pkg::RESP_DECERR));
   endtask
   task automatic t_seq;
      wr(timer_pkg::IDX_SHD_LOW, 8'h00);
      rc(timer_pkg::IDX_CNT_HIGH, 8'hFF);
      run(20);
      rc(timer_pkg::IDX_SHD_HIGH, 8'h00);
      rc(timer_pkg::IDX_CNT_LOW, 8'hFC);
      rc(timer_pkg::IDX_SHD_LOW, 8'h06);
   endtask
   task automatic t_div;
      for (int i = 0; i < 3; i++) begin
         wr(timer_pkg::IDX_CTRL_TWO, 8'(i << 2));
         wr(timer_pkg::IDX_CNT_LOW, 8'h00);
         run(64);
         rc(timer_pkg::IDX_CNT_HIGH, 8'h00);
         rc(timer_pkg::IDX_CNT_LOW, 8'hFC + 8'(64 >> (i + 1)));
      end
   endtask
   task automatic t_ovf;
      wr(timer_pkg::IDX_CTRL_TWO, 8'h00);
      wr(timer_pkg::IDX_CTRL_ONE, 8'h20);
      rc(timer_pkg::IDX_STATUS, 8'h20);
      rc(timer_pkg::IDX_SHD_LOW, 8'h04);
      rc(timer_pkg::IDX_STATUS, 8'h20);
      wr(timer_pkg::IDX_CNT_LOW, 8'h00);
      rc(timer_pkg::IDX_STATUS, 8'h00);
      run(10);
      rc(timer_pkg::IDX_STATUS, 8'h20);
      chk(8'(irq), 8'h00);
      mask <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      chk(8'(irq), 8'h01);
      rd(timer_pkg::IDX_CNT_LOW, v);
      rc(timer_pkg::IDX_STATUS, 8'h00);
      chk(8'(irq), 8'h00);
   endtask
   task automatic t_cap;
      logic [7:0] st;
      logic [3:0] hi;
      wr(timer_pkg::IDX_CTRL_ONE, 8'h82);
      wr(timer_pkg::IDX_CTRL_TWO, 8'h02);
      for (int ch = 0; ch < 2; ch++) begin
         st = (ch == 0) ? 8'h80 : 8'h10;
         hi = (ch == 0) ? timer_pkg::IDX_CAP1_HIGH : timer_pkg::IDX_CAP2_HIGH;
         wr(timer_pkg::IDX_CNT_LOW, 8'h00);
         pin_source_inst.cap_toggle(ch);
         repeat (6) @(posedge ref_clk_i);
         chk(8'(irq), 8'h01);
         rc(timer_pkg::IDX_STATUS, st);
         rc(hi, 8'hFF);
         run(6);
         repeat (2) pin_source_inst.cap_toggle(ch);
         rc(hi + 4'h1, 8'hFC);
         rc(timer_pkg::IDX_STATUS, 8'h00);
         pin_source_inst.cap_toggle(ch);
         rc(timer_pkg::IDX_STATUS, 8'h00);
         pin_source_inst.cap_toggle(ch);
         rc(timer_pkg::IDX_STATUS, st);
         rc(hi, 8'hFF);
         rc(hi + 4'h1, 8'hFF);
      end
      wr(timer_pkg::IDX_CTRL_TWO, 8'h12);
      repeat (2) pin_source_inst.cap_toggle(0);
      rc(timer_pkg::IDX_STATUS, 8'h00);
   endtask
   task automatic t_ext;
      @(posedge ref_clk_i);
      halt <= 1'b0;
      for (int e = 1; e >= 0; e--) begin
         wr(timer_pkg::IDX_CTRL_TWO, 8'h0C | 8'(e));
         wr(timer_pkg::IDX_CNT_LOW, 8'h00);
         repeat (3) pin_source_inst.ext_toggle();
         rc(timer_pkg::IDX_CNT_LOW, 8'hFE);
      end
      halt <= 1'b1;
   endtask
   task automatic t_cmp;
      wr(timer_pkg::IDX_CTRL_TWO, 8'h80);
      wr(timer_pkg::IDX_CTRL_ONE, 8'h41);
      wr(timer_pkg::IDX_CNT_LOW, 8'h00);
      wr(timer_pkg::IDX_CMP1_HIGH, 8'h00);
      wr(timer_pkg::IDX_CMP1_LOW, 8'h04);
      wr(timer_pkg::IDX_CMP2_HIGH, 8'h00);
      chk(8'({cmp_en, cmp_pin, irq}), 8'h08);
      run(30);
      chk(8'({cmp_en, cmp_pin, irq}), 8'h0B);
      rc(timer_pkg::IDX_STATUS, 8'h60);
      rc(timer_pkg::IDX_CMP1_HIGH, 8'h00);
      rc(timer_pkg::IDX_CMP1_LOW, 8'h04);
      wr(timer_pkg::IDX_CMP2_LOW, 8'h10);
      run(30);
      rc(timer_pkg::IDX_STATUS, 8'h28);
   endtask
   // Reset while the timer is halted, with the compare pin high and flags pending
   task automatic t_wake;
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      chk(8'({cmp_en, cmp_pin, irq}), 8'h00);
      rc(timer_pkg::IDX_CNT_LOW, 8'hFC);
      rc(timer_pkg::IDX_CMP2_LOW, 8'h00);
      rc(timer_pkg::IDX_STATUS, 8'h00);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100us;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_seq();
      t_div();
      t_ovf();
      t_cap();
      t_ext();
      t_cmp();
      t_wake();
      conclude();
   end
endmodule // free_timer_tb
`default_nettype wire

// [bench/pin_source.sv]
`timescale 1ns/10ps
`default_nettype none
module pin_source (
   input  wire logic ref_clk_i,
   output logic      ext_clk_o,
   output logic [1:0] cap_o
);
   initial begin
      ext_clk_o = 1'b0;
      cap_o     = 2'b00;
   end
   // External clock stands still between calls
   task automatic ext_toggle;
      @(posedge ref_clk_i);
      ext_clk_o <= ~ext_clk_o;
      repeat (4) @(posedge ref_clk_i);
   endtask
   task automatic cap_toggle(input int ch);
      @(posedge ref_clk_i);
      cap_o[ch] <= ~cap_o[ch];
      repeat (4) @(posedge ref_clk_i);
   endtask
endmodule // pin_source
`default_nettype wire

// [bench/timer_checks_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module timer_checks (
   input  wire logic                ref_clk_i,
   input  wire logic                rstn_i,
   input  wire timer_pkg::axi_req_t bus_req_i,
   input  wire timer_pkg::axi_rsp_t bus_rsp_o,
   input  wire logic                irq_mask_i,
   input  wire logic                halt_i,
   input  wire logic                external_clock_pin_i,
   input  wire logic [1:0]          capture_input_pin_i,
   input  wire logic [1:0]          compare_output_pin_o,
   input  wire logic [1:0]          compare_output_enable_o,
   input  wire logic                timer_irq_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_irq_masked; $past(irq_mask_i) |-> !timer_irq_o; endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
   property p_rd_upper; bus_rsp_o.rvalid |-> bus_rsp_o.rdata[31:8] == 24'h000000; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_r_hold;
      bus_rsp_o.rvalid && !bus_req_i.rready |=> bus_rsp_o.rvalid && $stable(bus_rsp_o.rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_b_hold;
      bus_rsp_o.bvalid && !bus_req_i.bready |=> bus_rsp_o.bvalid && $stable(bus_rsp_o.bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_ar_pulse; bus_rsp_o.arready |=> !bus_rsp_o.arready; endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("arready too long");
   property p_r_answer; bus_req_i.arvalid && bus_rsp_o.arready |=> bus_rsp_o.rvalid; endproperty
   a_r_answer: assert property (p_r_answer) else $error("no read answer");
   property p_b_answer;
      bus_req_i.awvalid && bus_req_i.wvalid && bus_rsp_o.awready |=> bus_rsp_o.bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("no write answer");
   property p_decerr;
      bus_req_i.arvalid && bus_rsp_o.arready && bus_req_i.araddr[5:2] == 4'hF
         |=> bus_rsp_o.rresp == timer_pkg::RESP_DECERR;
   endproperty
   a_decerr: assert property (p_decerr) else $error("unmapped read not refused");
   property p_ar_wait; bus_req_i.arvalid && !bus_rsp_o.rvalid |-> ##[0:3] bus_rsp_o.arready;
   endproperty
   a_ar_wait: assert property (p_ar_wait) else $error("read not taken");
   property p_pin_reset; $rose(rstn_i) |-> compare_output_pin_o == 2'b00 && !timer_irq_o;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pins not low after reset");
   c_irq: cover property (timer_irq_o);
   c_cmp: cover property ($rose(compare_output_pin_o[0]));
   c_decerr: cover property (bus_rsp_o.rvalid && bus_rsp_o.rresp == timer_pkg::RESP_DECERR);
   c_wr: cover property (bus_rsp_o.bvalid && bus_req_i.bready);
endmodule // timer_checks
bind free_timer timer_checks timer_checks_inst (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_req_i(bus_req_i), .bus_rsp_o(bus_rsp_o),
   .irq_mask_i(irq_mask_i), .halt_i(halt_i), .external_clock_pin_i(external_clock_pin_i),
   .capture_input_pin_i(capture_input_pin_i), .compare_output_pin_o(compare_output_pin_o),
   .compare_output_enable_o(compare_output_enable_o), .timer_irq_o(timer_irq_o));
`default_nettype wire

// [rtl/free_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module free_timer (
   input  wire logic               ref_clk_i,
   input  wire logic               rstn_i,
   input  wire timer_pkg::axi_req_t bus_req_i,
   output timer_pkg::axi_rsp_t     bus_rsp_o,
   input  wire logic               irq_mask_i,
   input  wire logic               halt_i,
   input  wire logic               external_clock_pin_i,
   input  wire logic [1:0]         capture_input_pin_i,
   output logic [1:0]              compare_output_pin_o,
   output logic [1:0]              compare_output_enable_o,
   output logic                    timer_irq_o
);

   function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
      edge_hit = rise ? (!prev && cur) : (prev && !cur);
   endfunction

   // Flag bits that an access to a given register may clear
   function automatic logic [7:0] clear_bits(input logic [timer_pkg::IDX_W-1:0] idx);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         timer_pkg::IDX_CNT_LOW: begin
            b[timer_pkg::SR_TOF] = 1'b1;
         end
         timer_pkg::IDX_CAP1_LOW: begin
            b[timer_pkg::SR_ICF1] = 1'b1;
         end
         timer_pkg::IDX_CAP2_LOW: begin
            b[timer_pkg::SR_ICF2] = 1'b1;
         end
         timer_pkg::IDX_CMP1_LOW: begin
            b[timer_pkg::SR_OCF1] = 1'b1;
         end
         timer_pkg::IDX_CMP2_LOW: begin
            b[timer_pkg::SR_OCF2] = 1'b1;
         end
         default: begin
            b = 8'h00;
         end
      endcase
      clear_bits = b;
   endfunction

   logic [7:0]  ctrl_one_q;
   logic [7:0]  ctrl_two_q;
   logic [7:0]  status_q;
   logic [7:0]  status_d;
   logic [7:0]  arm_q;
   logic [7:0]  set_vec;
   logic [7:0]  clr_vec;
   logic [15:0] count_q;
   logic [2:0]  pre_q;
   logic [2:0]  pre_mask;
   logic        tick;
   logic        count_reload;
   logic [7:0]  snap_q;
   logic        snap_valid_q;
   logic [15:0] cap_q [2];
   logic [15:0] cmp_q [2];
   logic [1:0]  cap_block_q;
   logic [1:0]  cmp_hold_q;
   logic [1:0]  cap_edge;
   logic [1:0]  cap_go;
   logic [1:0]  cmp_match;
   logic [1:0]  cap_edge_sel;
   logic [1:0]  cmp_level;
   logic [1:0]  cmp_oe;
   logic [2:0]  sync1_q;
   logic [2:0]  sync2_q;
   logic [2:0]  sync3_q;
   logic        ext_edge;
   logic        pulse_mode;
   logic        aw_rdy_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        ar_rdy_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [1:0]  pin_q;
   logic [1:0]  oe_q;
   logic        irq_q;
   logic        wr_go;
   logic        rd_go;
   logic        wr_byte;
   logic [timer_pkg::IDX_W-1:0] widx;
   logic [timer_pkg::IDX_W-1:0] ridx;
   logic [7:0]  wbyte;
   logic [7:0]  rd_byte;
   logic        rd_hit;

   assign widx    = bus_req_i.awaddr[timer_pkg::ADDR_W-1:2];
   assign ridx    = bus_req_i.araddr[timer_pkg::ADDR_W-1:2];
   assign wbyte   = bus_req_i.wdata[7:0];
   assign wr_go   = aw_rdy_q;
   assign rd_go   = ar_rdy_q;
   assign wr_byte = wr_go && bus_req_i.wstrb[0];

   assign cap_edge_sel = {ctrl_two_q[timer_pkg::C2_IEDG2], ctrl_one_q[timer_pkg::C1_IEDG1]};
   assign cmp_level    = {ctrl_one_q[timer_pkg::C1_OLVL2], ctrl_one_q[timer_pkg::C1_OLVL1]};
   assign cmp_oe       = {ctrl_two_q[timer_pkg::C2_OC2E], ctrl_two_q[timer_pkg::C2_OC1E]};
   assign pulse_mode   = ctrl_two_q[timer_pkg::C2_OPM] || ctrl_two_q[timer_pkg::C2_PWM];

   // Pin synchronisers: bit 2 external clock, bits 1:0 capture pins
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
      end else begin
         sync1_q <= {external_clock_pin_i, capture_input_pin_i};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Timer tick selection
   always_comb begin
      case (ctrl_two_q[timer_pkg::C2_CC_LSB +: 2])
         timer_pkg::CLK_DIV2: pre_mask = timer_pkg::MASK_DIV2;
         timer_pkg::CLK_DIV4: pre_mask = timer_pkg::MASK_DIV4;
         timer_pkg::CLK_DIV8: pre_mask = timer_pkg::MASK_DIV8;
         default:             pre_mask = timer_pkg::MASK_DIV8;
      endcase
   end

   // Active external edge; source keeps edges five clocks apart
   assign ext_edge = edge_hit(sync3_q[2], sync2_q[2], ctrl_two_q[timer_pkg::C2_EXTERNAL_CLOCK_EDGE_SELECT]);

   always_comb begin
      if (halt_i) begin
         tick = 1'b0;
      end else if (ctrl_two_q[timer_pkg::C2_CC_LSB +: 2] == timer_pkg::CLK_EXT) begin
         tick = ext_edge;
      end else begin
         tick = ((pre_q & pre_mask) == pre_mask);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         pre_q <= 3'h0;
      end else if (!halt_i) begin
         pre_q <= pre_q + 3'h1;
      end
   end

   // Free-running counter
   assign count_reload = wr_go && (widx == timer_pkg::IDX_CNT_LOW || widx == timer_pkg::IDX_SHD_LOW);

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         count_q <= timer_pkg::COUNT_RELOAD;
      end else if (count_reload) begin
         count_q <= timer_pkg::COUNT_RELOAD;
      end else if (tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // Low byte snapshot for the high-then-low read sequence
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         snap_q       <= 8'h00;
         snap_valid_q <= 1'b0;
      end else if (rd_go && (ridx == timer_pkg::IDX_CNT_LOW || ridx == timer_pkg::IDX_SHD_LOW)) begin
         snap_valid_q <= 1'b0;
      end else if (rd_go && (ridx == timer_pkg::IDX_CNT_HIGH || ridx == timer_pkg::IDX_SHD_HIGH)
                   && !snap_valid_q) begin
         snap_q       <= count_q[7:0];
         snap_valid_q <= 1'b1;
      end
   end

   // Capture and compare events
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cap_edge[i]  = edge_hit(sync3_q[i], sync2_q[i], cap_edge_sel[i]);
         cap_go[i]    = cap_edge[i] && !cap_block_q[i] && !(i == 0 && pulse_mode);
         cmp_match[i] = tick && !cmp_hold_q[i] && (count_q == cmp_q[i]);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         cap_q[0] <= 16'h0000;
         cap_q[1] <= 16'h0000;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cap_go[i]) begin
               cap_q[i] <= count_q;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         cap_block_q <= 2'h0;
      end else if (rd_go) begin
         if (ridx == timer_pkg::IDX_CAP1_HIGH) cap_block_q[0] <= 1'b1;
         if (ridx == timer_pkg::IDX_CAP1_LOW)  cap_block_q[0] <= 1'b0;
         if (ridx == timer_pkg::IDX_CAP2_HIGH) cap_block_q[1] <= 1'b1;
         if (ridx == timer_pkg::IDX_CAP2_LOW)  cap_block_q[1] <= 1'b0;
      end
   end

   // Compare registers, written only by software
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         cmp_q[0]   <= timer_pkg::CMP_RESET;
         cmp_q[1]   <= timer_pkg::CMP_RESET;
         cmp_hold_q <= 2'h0;
      end else if (wr_byte) begin
         case (widx)
            timer_pkg::IDX_CMP1_HIGH: begin
               cmp_q[0][15:8] <= wbyte;
               cmp_hold_q[0]  <= 1'b1;
            end
            timer_pkg::IDX_CMP1_LOW: begin
               cmp_q[0][7:0]  <= wbyte;
               cmp_hold_q[0]  <= 1'b0;
            end
            timer_pkg::IDX_CMP2_HIGH: begin
               cmp_q[1][15:8] <= wbyte;
               cmp_hold_q[1]  <= 1'b1;
            end
            timer_pkg::IDX_CMP2_LOW: begin
               cmp_q[1][7:0]  <= wbyte;
               cmp_hold_q[1]  <= 1'b0;
            end
            default: begin
               cmp_hold_q <= cmp_hold_q;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         pin_q <= 2'h0;
         oe_q  <= 2'h0;
      end else begin
         oe_q <= cmp_oe;
         for (int i = 0; i < 2; i++) begin
            if (cmp_match[i] && cmp_oe[i]) begin
               pin_q[i] <= cmp_level[i];
            end
         end
      end
   end

   // Control registers
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ctrl_one_q <= timer_pkg::CTRL_RESET;
         ctrl_two_q <= timer_pkg::CTRL_RESET;
      end else if (wr_byte) begin
         if (widx == timer_pkg::IDX_CTRL_ONE) ctrl_one_q <= wbyte;
         if (widx == timer_pkg::IDX_CTRL_TWO) ctrl_two_q <= wbyte;
      end
   end

   // Status flags: set wins over clear
   always_comb begin
      set_vec = 8'h00;
      set_vec[timer_pkg::SR_TOF]  = tick && (count_q == timer_pkg::COUNT_TOP) && !count_reload;
      set_vec[timer_pkg::SR_ICF1] = cap_go[0];
      set_vec[timer_pkg::SR_ICF2] = cap_go[1];
      set_vec[timer_pkg::SR_OCF1] = cmp_match[0];
      set_vec[timer_pkg::SR_OCF2] = cmp_match[1];
      clr_vec = 8'h00;
      if (wr_go) begin
         clr_vec = clr_vec | clear_bits(widx);
      end
      if (rd_go) begin
         clr_vec = clr_vec | clear_bits(ridx);
      end
      clr_vec  = clr_vec & arm_q;
      status_d = (status_q & ~clr_vec) | set_vec;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         status_q <= 8'h00;
         arm_q    <= 8'h00;
      end else begin
         status_q <= status_d;
         if (rd_go && ridx == timer_pkg::IDX_STATUS) begin
            arm_q <= status_q;
         end else begin
            arm_q <= arm_q & ~clr_vec;
         end
      end
   end

   // Single interrupt line, pending flags held until enabled and unmasked
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= !irq_mask_i && (
                  (status_q[timer_pkg::SR_TOF] && ctrl_one_q[timer_pkg::C1_OVF_IE])
               || ((status_q[timer_pkg::SR_ICF1] || status_q[timer_pkg::SR_ICF2])
                   && ctrl_one_q[timer_pkg::C1_CAP_IE])
               || ((status_q[timer_pkg::SR_OCF1] || status_q[timer_pkg::SR_OCF2])
                   && ctrl_one_q[timer_pkg::C1_CMP_IE]));
      end
   end

   // Read data mux
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (ridx)
         timer_pkg::IDX_CTRL_ONE:  rd_byte = ctrl_one_q;
         timer_pkg::IDX_CTRL_TWO:  rd_byte = ctrl_two_q;
         timer_pkg::IDX_STATUS:    rd_byte = status_q;
         timer_pkg::IDX_CAP1_HIGH: rd_byte = cap_q[0][15:8];
         timer_pkg::IDX_CAP1_LOW:  rd_byte = cap_q[0][7:0];
         timer_pkg::IDX_CMP1_HIGH: rd_byte = cmp_q[0][15:8];
         timer_pkg::IDX_CMP1_LOW:  rd_byte = cmp_q[0][7:0];
         timer_pkg::IDX_CNT_HIGH:  rd_byte = count_q[15:8];
         timer_pkg::IDX_SHD_HIGH:  rd_byte = count_q[15:8];
         timer_pkg::IDX_CNT_LOW:   rd_byte = snap_valid_q ? snap_q : count_q[7:0];
         timer_pkg::IDX_SHD_LOW:   rd_byte = snap_valid_q ? snap_q : count_q[7:0];
         timer_pkg::IDX_CAP2_HIGH: rd_byte = cap_q[1][15:8];
         timer_pkg::IDX_CAP2_LOW:  rd_byte = cap_q[1][7:0];
         timer_pkg::IDX_CMP2_HIGH: rd_byte = cmp_q[1][15:8];
         timer_pkg::IDX_CMP2_LOW:  rd_byte = cmp_q[1][7:0];
         default:                  rd_hit  = 1'b0;
      endcase
   end

   // AXI4-Lite write channel
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         aw_rdy_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= timer_pkg::RESP_OKAY;
      end else begin
         aw_rdy_q <= bus_req_i.awvalid && bus_req_i.wvalid && !aw_rdy_q && !bvalid_q;
         if (aw_rdy_q) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (widx <= timer_pkg::IDX_LAST) ? timer_pkg::RESP_OKAY
                                                       : timer_pkg::RESP_DECERR;
         end else if (bus_req_i.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= timer_pkg::RESP_OKAY;
      end else begin
         ar_rdy_q <= bus_req_i.arvalid && !ar_rdy_q && !rvalid_q;
         if (ar_rdy_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_DECERR;
         end else if (bus_req_i.rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      bus_rsp_o.awready = aw_rdy_q;
      bus_rsp_o.wready  = aw_rdy_q;
      bus_rsp_o.bvalid  = bvalid_q;
      bus_rsp_o.bresp   = bresp_q;
      bus_rsp_o.arready = ar_rdy_q;
      bus_rsp_o.rvalid  = rvalid_q;
      bus_rsp_o.rdata   = rdata_q;
      bus_rsp_o.rresp   = rresp_q;
   end

   assign compare_output_pin_o    = pin_q;
   assign compare_output_enable_o = oe_q;
   assign timer_irq_o             = irq_q;

endmodule // free_timer
`default_nettype wire

// [rtl/timer_pkg.sv]
`default_nettype none
package timer_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 4;
   // Word index of each byte register (byte address = 4 * index)
   localparam logic [IDX_W-1:0] IDX_CTRL_ONE  = 4'h0;
   localparam logic [IDX_W-1:0] IDX_CTRL_TWO  = 4'h1;
   localparam logic [IDX_W-1:0] IDX_STATUS    = 4'h2;
   localparam logic [IDX_W-1:0] IDX_CAP1_HIGH = 4'h3;
   localparam logic [IDX_W-1:0] IDX_CAP1_LOW  = 4'h4;
   localparam logic [IDX_W-1:0] IDX_CMP1_HIGH = 4'h5;
   localparam logic [IDX_W-1:0] IDX_CMP1_LOW  = 4'h6;
   localparam logic [IDX_W-1:0] IDX_CNT_HIGH  = 4'h7;
   localparam logic [IDX_W-1:0] IDX_CNT_LOW   = 4'h8;
   localparam logic [IDX_W-1:0] IDX_SHD_HIGH  = 4'h9;
   localparam logic [IDX_W-1:0] IDX_SHD_LOW   = 4'hA;
   localparam logic [IDX_W-1:0] IDX_CAP2_HIGH = 4'hB;
   localparam logic [IDX_W-1:0] IDX_CAP2_LOW  = 4'hC;
   localparam logic [IDX_W-1:0] IDX_CMP2_HIGH = 4'hD;
   localparam logic [IDX_W-1:0] IDX_CMP2_LOW  = 4'hE;
   localparam logic [IDX_W-1:0] IDX_LAST      = 4'hE;
   // Control register one bits
   localparam int C1_CAP_IE  = 7;
   localparam int C1_CMP_IE  = 6;
   localparam int C1_OVF_IE  = 5;
   localparam int C1_OLVL2   = 2;
   localparam int C1_IEDG1   = 1;
   localparam int C1_OLVL1   = 0;
   // Control register two bits
   localparam int C2_OC1E    = 7;
   localparam int C2_OC2E    = 6;
   localparam int C2_PWM     = 5;
   localparam int C2_OPM     = 4;
   localparam int C2_CC_LSB  = 2;
   localparam int C2_IEDG2   = 1;
   localparam int C2_EXTERNAL_CLOCK_EDGE_SELECT   = 0;
   // Status register bits
   localparam int SR_ICF1    = 7;
   localparam int SR_OCF1    = 6;
   localparam int SR_TOF     = 5;
   localparam int SR_ICF2    = 4;
   localparam int SR_OCF2    = 3;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
   localparam logic [15:0] COUNT_TOP    = 16'hFFFF;
   localparam logic [15:0] CMP_RESET    = 16'h8000;
   localparam logic [1:0]  CLK_DIV2     = 2'h0;
   localparam logic [1:0]  CLK_DIV4     = 2'h1;
   localparam logic [1:0]  CLK_DIV8     = 2'h2;
   localparam logic [1:0]  CLK_EXT      = 2'h3;
   localparam logic [2:0]  MASK_DIV2    = 3'h1;
   localparam logic [2:0]  MASK_DIV4    = 3'h3;
   localparam logic [2:0]  MASK_DIV8    = 3'h7;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_DECERR  = 2'h3;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } axi_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } axi_rsp_t;
endpackage
`default_nettype wire
